// *** ssp_cfg.svh ***
// Constant definitions for the synchronous serial port transmit control block
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// ----------------------------------------------------------------------------
// I/O-space addresses
// ----------------------------------------------------------------------------
`define SSP_ADDR_DATA 16'hfff0
`define SSP_ADDR_CTRL 16'hfff1

// ----------------------------------------------------------------------------
// Port control register field positions
// ----------------------------------------------------------------------------
`define SSP_BIT_FRAME_MODE 1
`define SSP_BIT_CLK_SRC 2
`define SSP_BIT_FRAME_SRC 3
`define SSP_BIT_RX_RST_N 4
`define SSP_BIT_TX_RST_N 5
`define SSP_BIT_RX_LVL_LO 8
`define SSP_BIT_RX_LVL_HI 9
`define SSP_BIT_TX_LVL_LO 10
`define SSP_BIT_TX_LVL_HI 11
`define SSP_BIT_RX_HAS_DATA 12
`define SSP_BIT_TX_DONE 13

// ----------------------------------------------------------------------------
// Sizes, reset values and vectors
// ----------------------------------------------------------------------------
`define SSP_WORD_W 16
`define SSP_FIFO_DEPTH 4
`define SSP_CNT_W 3
`define SSP_PTR_W 2
`define SSP_CTRL_RESET 16'h0000
`define SSP_RX_VECTOR 16'h0008
`define SSP_TX_VECTOR 16'h000a

`endif

// *** ssp_pkg.sv ***
// Types shared by the synchronous serial port transmit control block
`include "ssp_cfg.svh"

package ssp_pkg;

  // --------------------------------------------------------------------------
  // State machines
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SHIFT} ssp_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_SHIFT} ssp_rx_state_type;

  // --------------------------------------------------------------------------
  // Writable fields of the port control register
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] tx_level_sel;       // Transmit interrupt level, hi/lo
    logic [1:0] rx_level_sel;       // Receive interrupt level, hi/lo
    logic tx_section_reset_n;       // 0 holds the transmitter in reset
    logic rx_section_reset_n;       // 0 holds the receiver in reset
    logic frame_source_select;      // 1 internal frame pulse
    logic clock_source_select;      // 1 internal bit clock
    logic frame_mode_select;        // 1 burst, 0 continuous
  } ssp_ctrl_type;

  // --------------------------------------------------------------------------
  // Processor I/O-space access
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;              // I/O address
    logic wr;                       // One-cycle write strobe
    logic rd;                       // One-cycle read strobe
    logic [`SSP_WORD_W-1:0] wdata;  // Write data
  } ssp_io_req_type;

endpackage

// *** ssp_sync2.sv ***
// Two-flop level synchroniser, one bit per lane
`timescale 1ns/1ns
`default_nettype none

module ssp_sync2 #(
  parameter int W = 1
) (
  // Destination clock
  input wire logic clk_i,
  // Levels from the other domain
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  // --------------------------------------------------------------------------
  // Lanes
  // --------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_lane
      logic meta_ff;   // First stage, read only by the second
      logic stable_ff; // Second stage
      // No reset: the stages settle within two edges of a running clock
      always_ff @(posedge clk_i) begin
        meta_ff <= async_i[g];
        stable_ff <= meta_ff;
      end
      assign sync_o[g] = stable_ff;
    end
  endgenerate

endmodule

`default_nettype wire

// *** ssp_fifo4.sv ***
// Four-word FIFO with drop-on-full push, used for transmit and receive
`timescale 1ns/1ns
`default_nettype none
`include "ssp_cfg.svh"

module ssp_fifo4 (
  // Clock and synchronous clear
  input wire logic clk_i,
  input wire logic clr_i,
  // Fill side
  input wire logic push_i,
  input wire logic [`SSP_WORD_W-1:0] wdata_i,
  // Drain side
  input wire logic pop_i,
  output logic [`SSP_WORD_W-1:0] rdata_o,
  output logic [`SSP_CNT_W-1:0] count_o
);

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  logic [`SSP_WORD_W-1:0] mem_ff [`SSP_FIFO_DEPTH]; // Word array
  logic [`SSP_PTR_W-1:0] wr_ptr_ff; // Next slot to fill
  logic [`SSP_PTR_W-1:0] rd_ptr_ff; // Oldest word
  logic [`SSP_CNT_W-1:0] cnt_ff; // Words held
  logic do_push; // Push accepted
  logic do_pop; // Pop accepted

  // A push into a full FIFO is dropped and its word lost
  assign do_push = push_i && (cnt_ff != `SSP_CNT_W'(`SSP_FIFO_DEPTH));
  assign do_pop = pop_i && (cnt_ff != '0);
  assign rdata_o = mem_ff[rd_ptr_ff];
  assign count_o = cnt_ff;

  // Word array has no reset; only slots below the count are ever read
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_ff[wr_ptr_ff] <= wdata_i;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_i) begin
    if (clr_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_ff <= wr_ptr_ff + `SSP_PTR_W'(1);
      end
      if (do_pop) begin
        rd_ptr_ff <= rd_ptr_ff + `SSP_PTR_W'(1);
      end
      if (do_push && !do_pop) begin
        cnt_ff <= cnt_ff + `SSP_CNT_W'(1);
      end else if (do_pop && !do_push) begin
        cnt_ff <= cnt_ff - `SSP_CNT_W'(1);
      end
    end
  end

endmodule

`default_nettype wire

// *** ssp_top.sv ***
// Synchronous serial port: control register, FIFOs and serial transmitter
`timescale 1ns/1ns
`default_nettype none
`include "ssp_cfg.svh"

module ssp_top (
  // Processor clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Processor I/O-space access
  input wire ssp_pkg::ssp_io_req_type io_req_i,
  output logic [`SSP_WORD_W-1:0] io_rdata_o,
  // Interrupt lines to the processor
  output logic tx_fifo_irq_o,
  output logic rx_fifo_irq_o,
  // Bit clock pin: resolved level in, internal drive out
  input wire logic tx_bit_clock_i,
  output logic tx_bit_clock_o,
  output logic tx_bit_clock_oe_o,
  // Transmit frame pulse pin
  input wire logic tx_frame_pulse_i,
  output logic tx_frame_pulse_o,
  output logic tx_frame_pulse_oe_o,
  // Serial data and receive framing
  output logic serial_data_out_o,
  input wire logic rx_frame_pulse_i,
  input wire logic serial_data_in_i
);
  import ssp_pkg::*;

  // --------------------------------------------------------------------------
  // Decoding helper
  // --------------------------------------------------------------------------
  // Level code n is met when the measured amount reaches n+1 words
  function automatic logic level_hit(input logic [`SSP_CNT_W-1:0] amount,
                                     input logic [1:0] sel);
    level_hit = amount > {1'b0, sel};
  endfunction

  // --------------------------------------------------------------------------
  // Processor-domain declarations
  // --------------------------------------------------------------------------
  ssp_ctrl_type ctrl_ff; // Writable control fields
  logic fsm_lat_ff; // Frame mode in effect
  logic clk_div_ff; // Internal bit clock divider
  logic clk_oe_ff; // Bit clock pin driven
  logic frame_oe_ff; // Frame pin driven
  logic offer_ff; // Toggles when a word is offered to the link
  logic offered_ff; // A word is on offer, not yet taken
  logic [`SSP_WORD_W-1:0] offer_word_ff; // Word on offer, stable until taken
  logic take_seen_ff; // Last take toggle seen
  logic rx_seen_ff; // Last receive toggle seen
  logic [`SSP_WORD_W-1:0] rdata_ff; // Read data
  logic tx_irq_ff; // Transmit interrupt line
  logic rx_irq_ff; // Receive interrupt line
  logic take_ms; // Take toggle, synchronised
  logic rx_tog_ms; // Receive toggle, synchronised
  logic wr_data; // Data register write
  logic wr_ctrl; // Control register write
  logic rd_data; // Data register read
  logic rd_ctrl; // Control register read
  logic tx_push; // Word into transmit FIFO
  logic tx_pop; // Word taken by the link
  logic rx_push; // Received word into FIFO
  logic rx_pop; // Word read by software
  logic [`SSP_WORD_W-1:0] tx_head; // Oldest transmit word
  logic [`SSP_WORD_W-1:0] rx_head; // Oldest received word
  logic [`SSP_CNT_W-1:0] tx_cnt; // Transmit words queued
  logic [`SSP_CNT_W-1:0] rx_cnt; // Received words held
  logic [`SSP_CNT_W-1:0] tx_free; // Transmit slots free
  logic [`SSP_WORD_W-1:0] ctrl_rd; // Control register image

  // --------------------------------------------------------------------------
  // Link-domain declarations
  // --------------------------------------------------------------------------
  ssp_tx_state_type tx_state_ff; // Transmitter state
  ssp_rx_state_type rx_state_ff; // Receiver state
  logic [`SSP_WORD_W-1:0] tx_shift_register_ff; // Outgoing word
  logic [4:0] tx_bits_ff; // Bits still to drive
  logic take_ff; // Toggles when the offered word is loaded
  logic frame_ff; // Internal frame pulse
  logic dout_ff; // Serial data bit
  logic [`SSP_WORD_W-1:0] rx_sh_ff; // Incoming bits
  logic [4:0] rx_bits_ff; // Bits still to sample
  logic [`SSP_WORD_W-1:0] rx_word_ff; // Last full word, stable one word time
  logic rx_tog_ff; // Toggles per received word
  logic tx_en_ls; // Transmit section running
  logic rx_en_ls; // Receive section running
  logic burst_ls; // Frame mode in effect
  logic int_fs_ls; // Internal frame pulse selected
  logic offer_ls; // Offer toggle, synchronised
  logic avail; // A fresh word is on offer
  logic frame_ok; // Frame condition to start from idle

  // --------------------------------------------------------------------------
  // Register access decode
  // --------------------------------------------------------------------------
  assign wr_data = io_req_i.wr && (io_req_i.addr == `SSP_ADDR_DATA);
  assign wr_ctrl = io_req_i.wr && (io_req_i.addr == `SSP_ADDR_CTRL);
  assign rd_data = io_req_i.rd && (io_req_i.addr == `SSP_ADDR_DATA);
  assign rd_ctrl = io_req_i.rd && (io_req_i.addr == `SSP_ADDR_CTRL);

  // Writes reach the FIFO only while the transmitter runs
  assign tx_push = wr_data && ctrl_ff.tx_section_reset_n;
  assign tx_pop = offered_ff && (take_ms != take_seen_ff)
                  && ctrl_ff.tx_section_reset_n;
  assign rx_push = (rx_tog_ms != rx_seen_ff) && ctrl_ff.rx_section_reset_n;
  assign rx_pop = rd_data && (rx_cnt != '0);
  assign tx_free = `SSP_CNT_W'(`SSP_FIFO_DEPTH) - tx_cnt;

  // Control image; unlisted bits read as zero
  always_comb begin
    ctrl_rd = `SSP_CTRL_RESET;
    ctrl_rd[`SSP_BIT_FRAME_MODE] = ctrl_ff.frame_mode_select;
    ctrl_rd[`SSP_BIT_CLK_SRC] = ctrl_ff.clock_source_select;
    ctrl_rd[`SSP_BIT_FRAME_SRC] = ctrl_ff.frame_source_select;
    ctrl_rd[`SSP_BIT_RX_RST_N] = ctrl_ff.rx_section_reset_n;
    ctrl_rd[`SSP_BIT_TX_RST_N] = ctrl_ff.tx_section_reset_n;
    ctrl_rd[`SSP_BIT_RX_LVL_HI:`SSP_BIT_RX_LVL_LO] = ctrl_ff.rx_level_sel;
    ctrl_rd[`SSP_BIT_TX_LVL_HI:`SSP_BIT_TX_LVL_LO] = ctrl_ff.tx_level_sel;
    ctrl_rd[`SSP_BIT_RX_HAS_DATA] = (rx_cnt != '0);
    ctrl_rd[`SSP_BIT_TX_DONE] = (tx_cnt != '0);
  end

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  // Both sections come up held in reset until software releases them
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ctrl_ff <= '0;
    end else if (wr_ctrl) begin
      ctrl_ff.frame_mode_select <= io_req_i.wdata[`SSP_BIT_FRAME_MODE];
      ctrl_ff.clock_source_select <= io_req_i.wdata[`SSP_BIT_CLK_SRC];
      ctrl_ff.frame_source_select <= io_req_i.wdata[`SSP_BIT_FRAME_SRC];
      ctrl_ff.rx_section_reset_n <= io_req_i.wdata[`SSP_BIT_RX_RST_N];
      ctrl_ff.tx_section_reset_n <= io_req_i.wdata[`SSP_BIT_TX_RST_N];
      ctrl_ff.rx_level_sel <= io_req_i.wdata[`SSP_BIT_RX_LVL_HI:`SSP_BIT_RX_LVL_LO];
      ctrl_ff.tx_level_sel <= io_req_i.wdata[`SSP_BIT_TX_LVL_HI:`SSP_BIT_TX_LVL_LO];
    end
  end

  // Frame mode follows the register only while the transmitter is in reset,
  // so a change in mid-stream cannot switch modes under a live word
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      fsm_lat_ff <= 1'b0;
    end else if (!ctrl_ff.tx_section_reset_n) begin
      fsm_lat_ff <= ctrl_ff.frame_mode_select;
    end
  end

  // Read data, one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_ff <= '0;
    end else if (rd_data) begin
      rdata_ff <= (rx_cnt != '0) ? rx_head : '0;
    end else if (rd_ctrl) begin
      rdata_ff <= ctrl_rd;
    end else if (io_req_i.rd) begin
      rdata_ff <= '0;
    end
  end

  // --------------------------------------------------------------------------
  // Pin drive in the processor domain
  // --------------------------------------------------------------------------
  // Divider runs always; the pin is driven only when selected
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      clk_div_ff <= 1'b0;
      clk_oe_ff <= 1'b0;
      frame_oe_ff <= 1'b0;
    end else begin
      clk_div_ff <= ~clk_div_ff;
      clk_oe_ff <= ctrl_ff.clock_source_select;
      frame_oe_ff <= ctrl_ff.frame_source_select;
    end
  end

  // --------------------------------------------------------------------------
  // FIFOs
  // --------------------------------------------------------------------------
  ssp_fifo4 u_tx_fifo (
    .clk_i(mclk_i),
    .clr_i(srst_i || !ctrl_ff.tx_section_reset_n),
    .push_i(tx_push),
    .wdata_i(io_req_i.wdata),
    .pop_i(tx_pop),
    .rdata_o(tx_head),
    .count_o(tx_cnt)
  );

  ssp_fifo4 u_rx_fifo (
    .clk_i(mclk_i),
    .clr_i(srst_i || !ctrl_ff.rx_section_reset_n),
    .push_i(rx_push),
    .wdata_i(rx_word_ff),
    .pop_i(rx_pop),
    .rdata_o(rx_head),
    .count_o(rx_cnt)
  );

  // --------------------------------------------------------------------------
  // Word hand-off toward the link
  // --------------------------------------------------------------------------
  // One word at a time is offered by a toggle; its data stays put until the
  // link toggles back, so the data bus needs no synchroniser of its own
  always_ff @(posedge mclk_i) begin
    if (srst_i || !ctrl_ff.tx_section_reset_n) begin
      offer_ff <= 1'b0;
      offered_ff <= 1'b0;
      offer_word_ff <= '0;
    end else if (tx_pop) begin
      offered_ff <= 1'b0;
    end else if (!offered_ff && (tx_cnt != '0)) begin
      offered_ff <= 1'b1;
      offer_ff <= ~offer_ff;
      offer_word_ff <= tx_head;
    end
  end

  // Edge trackers for the toggles coming back from the link
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      take_seen_ff <= 1'b0;
      rx_seen_ff <= 1'b0;
    end else begin
      take_seen_ff <= take_ms;
      rx_seen_ff <= rx_tog_ms;
    end
  end

  ssp_sync2 #(.W(2)) u_sync_to_cpu (
    .clk_i(mclk_i),
    .async_i({take_ff, rx_tog_ff}),
    .sync_o({take_ms, rx_tog_ms})
  );

  // --------------------------------------------------------------------------
  // Interrupt lines
  // --------------------------------------------------------------------------
  // Level driven; the processor latches them into its own pending flags
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      tx_irq_ff <= 1'b0;
      rx_irq_ff <= 1'b0;
    end else begin
      // Free space against the level code, or the load that emptied the FIFO
      tx_irq_ff <= ctrl_ff.tx_section_reset_n
                   && (level_hit(tx_free, ctrl_ff.tx_level_sel)
                       || (tx_pop && (tx_cnt == `SSP_CNT_W'(1))));
      rx_irq_ff <= ctrl_ff.rx_section_reset_n
                   && level_hit(rx_cnt, ctrl_ff.rx_level_sel);
    end
  end

  // --------------------------------------------------------------------------
  // Crossing into the link domain
  // --------------------------------------------------------------------------
  ssp_sync2 #(.W(5)) u_sync_to_link (
    .clk_i(tx_bit_clock_i),
    .async_i({ctrl_ff.tx_section_reset_n, ctrl_ff.rx_section_reset_n,
              fsm_lat_ff, ctrl_ff.frame_source_select, offer_ff}),
    .sync_o({tx_en_ls, rx_en_ls, burst_ls, int_fs_ls, offer_ls})
  );

  assign avail = offer_ls != take_ff;
  // Internal framing starts on the write alone; external waits for the pin
  assign frame_ok = int_fs_ls || tx_frame_pulse_i;

  // --------------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------------
  // Runs on the bit clock; a cleared section reset halts it mid-word once it has passed the two-flop synchroniser
  always_ff @(posedge tx_bit_clock_i) begin
    if (!tx_en_ls) begin
      tx_state_ff <= TX_IDLE;
      tx_shift_register_ff <= '0;
      tx_bits_ff <= '0;
      take_ff <= 1'b0;
      frame_ff <= 1'b0;
      dout_ff <= 1'b0;
    end else begin
      case (tx_state_ff)
        TX_IDLE: begin
          frame_ff <= 1'b0;
          if (avail && frame_ok) begin
            tx_state_ff <= TX_LOAD;
            frame_ff <= int_fs_ls;
          end
        end
        TX_LOAD: begin
          // Oldest word in, pulse down, MSB out on the same edge
          tx_shift_register_ff <= offer_word_ff;
          dout_ff <= offer_word_ff[`SSP_WORD_W-1];
          frame_ff <= 1'b0;
          take_ff <= ~take_ff;
          tx_bits_ff <= 5'(`SSP_WORD_W - 1);
          tx_state_ff <= TX_SHIFT;
        end
        TX_SHIFT: begin
          dout_ff <= tx_shift_register_ff[`SSP_WORD_W-2];
          tx_shift_register_ff <= {tx_shift_register_ff[`SSP_WORD_W-2:0], 1'b0};
          tx_bits_ff <= tx_bits_ff - 5'd1;
          if (tx_bits_ff == 5'd1) begin
            // This edge drives the LSB; decide what follows it
            if (avail && burst_ls && int_fs_ls) begin
              frame_ff <= 1'b1;
              tx_state_ff <= TX_LOAD;
            end else if (avail && !burst_ls) begin
              tx_state_ff <= TX_LOAD;
            end else begin
              tx_state_ff <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_state_ff <= TX_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------------
  // Shares the bit clock: the one resolved bit clock pin, driven by either end, clocks both directions
  always_ff @(posedge tx_bit_clock_i) begin
    if (!rx_en_ls) begin
      rx_state_ff <= RX_IDLE;
      rx_sh_ff <= '0;
      rx_bits_ff <= '0;
      rx_word_ff <= '0;
      rx_tog_ff <= 1'b0;
    end else begin
      case (rx_state_ff)
        RX_IDLE: begin
          if (rx_frame_pulse_i) begin
            rx_state_ff <= RX_SHIFT;
            rx_bits_ff <= 5'(`SSP_WORD_W);
          end
        end
        RX_SHIFT: begin
          rx_sh_ff <= {rx_sh_ff[`SSP_WORD_W-2:0], serial_data_in_i};
          rx_bits_ff <= rx_bits_ff - 5'd1;
          if (rx_bits_ff == 5'd1) begin
            rx_word_ff <= {rx_sh_ff[`SSP_WORD_W-2:0], serial_data_in_i};
            rx_tog_ff <= ~rx_tog_ff;
            // Continuous mode rolls straight into the next word
            if (burst_ls) begin
              rx_state_ff <= RX_IDLE;
            end else begin
              rx_bits_ff <= 5'(`SSP_WORD_W);
            end
          end
        end
        default: begin
          rx_state_ff <= RX_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign io_rdata_o = rdata_ff;
  assign tx_fifo_irq_o = tx_irq_ff;
  assign rx_fifo_irq_o = rx_irq_ff;
  assign tx_bit_clock_o = clk_div_ff;
  assign tx_bit_clock_oe_o = clk_oe_ff;
  assign tx_frame_pulse_o = frame_ff;
  assign tx_frame_pulse_oe_o = frame_oe_ff;
  assign serial_data_out_o = dout_ff;

endmodule

`default_nettype wire

// *** ssp_monitor.sv ***
// Concurrent checks on the serial port top ports
`timescale 1ns/1ns
`default_nettype none
module ssp_monitor (
  // Watched ports
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire ssp_pkg::ssp_io_req_type io_req_i,
  input wire logic [15:0] io_rdata_o,
  input wire logic tx_fifo_irq_o,
  input wire logic rx_fifo_irq_o,
  input wire logic tx_bit_clock_i,
  input wire logic tx_bit_clock_o,
  input wire logic tx_bit_clock_oe_o,
  input wire logic tx_frame_pulse_o,
  input wire logic tx_frame_pulse_oe_o
);
  // Control register write seen on the bus
  wire logic cw = io_req_i.wr && io_req_i.addr == 16'hfff1;
  a_reset_quiet: assert property (@(posedge mclk_i) srst_i |=>
    io_rdata_o == 16'h0000 && !tx_fifo_irq_o && !rx_fifo_irq_o) else $error("reset");
  a_clk_half_rate: assert property (@(posedge mclk_i) disable iff (srst_i)
    tx_bit_clock_oe_o && $past(tx_bit_clock_oe_o) |-> $changed(tx_bit_clock_o)) else $error("clk");
  a_clk_oe_follows: assert property (@(posedge mclk_i) disable iff (srst_i)
    cw |-> ##2 tx_bit_clock_oe_o == $past(io_req_i.wdata[2], 2)) else $error("clk oe");
  a_frame_oe_follows: assert property (@(posedge mclk_i) disable iff (srst_i)
    cw |-> ##2 tx_frame_pulse_oe_o == $past(io_req_i.wdata[3], 2)) else $error("frame oe");
  a_frame_one_cycle: assert property (@(posedge tx_bit_clock_i) disable iff (srst_i)
    $rose(tx_frame_pulse_o) |=> !tx_frame_pulse_o) else $error("frame width");
  a_unmapped_zero: assert property (@(posedge mclk_i) disable iff (srst_i)
    io_req_i.rd && io_req_i.addr[15:1] != 15'h7ff8 |=> io_rdata_o == 16'h0000) else $error("unmap");
  a_rdata_holds: assert property (@(posedge mclk_i) disable iff (srst_i)
    !io_req_i.rd |=> $stable(io_rdata_o)) else $error("rdata");
  a_section_quiet: assert property (@(posedge mclk_i) disable iff (srst_i)
    cw && !io_req_i.wdata[5] |-> ##3 !tx_fifo_irq_o) else $error("tx irq");
endmodule
bind ssp_top ssp_monitor mon (.mclk_i, .srst_i, .io_req_i, .io_rdata_o, .tx_fifo_irq_o,
  .rx_fifo_irq_o, .tx_bit_clock_i, .tx_bit_clock_o, .tx_bit_clock_oe_o, .tx_frame_pulse_o,
  .tx_frame_pulse_oe_o);
`default_nettype wire

// *** ssp_partner.sv ***
// External serial device: free bit clock and word catcher
`timescale 1ns/1ns
`default_nettype none
module ssp_partner (
  // Pin side
  input wire logic pin_clk_i,
  input wire logic frame_i,
  input wire logic data_i,
  output logic clk_o,
  output logic [15:0] last_o,
  output int cnt_o
);
  int n = 0;
  logic [15:0] sh;
  // Runs free: the port's link logic needs edges even while in reset
  initial begin
    clk_o = 1'b0;
    cnt_o = 0;
    #3;
    forever #80 clk_o = ~clk_o;
  end
  // Sample on falling edge, sixteen bits after each frame
  always @(negedge pin_clk_i) begin
    if (n != 0) begin
      sh = {sh[14:0], data_i};
      n = n - 1;
      if (n == 0) begin
        last_o = sh;
        cnt_o = cnt_o + 1;
      end
    end
    if (frame_i) n = 16;
  end
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the serial port top
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ssp_pkg::*;
  typedef struct {logic [15:0] a, d, e;} ssp_row_type;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  ssp_io_req_type req = '0;
  logic [15:0] rdata, last;
  logic tx_irq, rx_irq, clk_o, clk_oe, fr_o, fr_oe, dat, ext_clk;
  int cnt, error_cnt = 0, num_checks = 0;
  wire logic pin_clk = clk_oe ? clk_o : ext_clk;
  wire logic pin_fr = fr_oe ? fr_o : 1'b0;
  ssp_row_type rows [5] = '{'{16'hfff1, 16'hffc1, 16'h0f00}, '{16'hfff1, 16'h0006, 16'h0006},
    '{16'hfff2, 16'h1234, 16'h0000}, '{16'hfff0, 16'h5555, 16'h0000},
    '{16'hfff1, 16'h0000, 16'h0000}};
  ssp_top dut (.mclk_i, .srst_i, .io_req_i(req), .io_rdata_o(rdata), .tx_fifo_irq_o(tx_irq),
    .rx_fifo_irq_o(rx_irq), .tx_bit_clock_i(pin_clk), .tx_bit_clock_o(clk_o),
    .tx_bit_clock_oe_o(clk_oe), .tx_frame_pulse_i(pin_fr), .tx_frame_pulse_o(fr_o),
    .tx_frame_pulse_oe_o(fr_oe), .serial_data_out_o(dat), .rx_frame_pulse_i(pin_fr),
    .serial_data_in_i(dat));
  ssp_partner dev (.pin_clk_i(pin_clk), .frame_i(pin_fr), .data_i(dat), .clk_o(ext_clk),
    .last_o(last), .cnt_o(cnt));
  always #4 mclk_i = ~mclk_i;
  function automatic logic [15:0] w(input int i);
    return 16'ha5c3 ^ {4{4'(i)}};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One bus cycle, then a free cycle so read data settles
  task automatic io(input logic [15:0] a, input logic [15:0] d, input logic wr);
    @(negedge mclk_i);
    req = '{a, wr, !wr, d};
    @(negedge mclk_i);
    req = '0;
    @(negedge mclk_i);
  endtask
  task automatic wait_cnt(input int k);
    repeat (3000) if (cnt < k) @(negedge mclk_i);
    check(16'(cnt), 16'(k));
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #300000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    repeat (3) @(negedge mclk_i);
    srst_i = 1'b0;
    foreach (rows[i]) begin
      io(rows[i].a, rows[i].d, 1'b1);
      io(rows[i].a, 16'h0000, 1'b0);
      check(rdata, rows[i].e);
      repeat (20) @(negedge mclk_i);
    end
    // Mode is latched only while the transmitter is held, so write it with resets low first
    io(16'hfff1, 16'h000a, 1'b1);
    io(16'hfff1, 16'h002a, 1'b1);
    for (int i = 0; i < 5; i++) begin
      @(negedge mclk_i);
      req = '{16'hfff0, 1'b1, 1'b0, w(i)};
    end
    @(negedge mclk_i);
    req = '0;
    @(negedge mclk_i);
    check({15'h0000, tx_irq}, 16'h0000);
    io(16'hfff1, 16'h0000, 1'b0);
    check(rdata, 16'h202a);
    for (int i = 0; i < 4; i++) begin
      wait_cnt(i + 1);
      check(last, w(i));
    end
    repeat (800) @(negedge mclk_i);
    check(16'(cnt), 16'h0004);
    check({15'h0000, tx_irq}, 16'h0001);
    io(16'hfff1, 16'h003a, 1'b1);
    io(16'hfff0, 16'h3c5a, 1'b1);
    wait_cnt(5);
    repeat (60) @(negedge mclk_i);
    check({15'h0000, rx_irq}, 16'h0001);
    io(16'hfff1, 16'h0000, 1'b0);
    check(rdata, 16'h103a);
    io(16'hfff0, 16'h0000, 1'b0);
    check(rdata, 16'h3c5a);
    io(16'hfff1, 16'h001a, 1'b1);
    repeat (4) @(negedge mclk_i);
    check({15'h0000, tx_irq}, 16'h0000);
    // Continuous mode: one frame, two words back to back, caught by the looped receiver
    io(16'hfff1, 16'h0008, 1'b1);
    repeat (100) @(negedge mclk_i);
    io(16'hfff1, 16'h0038, 1'b1);
    io(16'hfff0, 16'h1357, 1'b1);
    io(16'hfff0, 16'h2468, 1'b1);
    repeat (900) @(negedge mclk_i);
    io(16'hfff0, 16'h0000, 1'b0);
    check(rdata, 16'h1357);
    io(16'hfff0, 16'h0000, 1'b0);
    check(rdata, 16'h2468);
    srst_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    srst_i = 1'b0;
    io(16'hfff1, 16'h0000, 1'b0);
    check(rdata, 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire
